// file: verilog/srs_defs.svh
// register map, field positions and fixed values of the reset/reload sequencer
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH
`define SRS_A_XL      8'h02
`define SRS_A_XH      8'h03
`define SRS_A_YL      8'h04
`define SRS_A_YH      8'h05
`define SRS_A_ZL      8'h06
`define SRS_A_ZH      8'h07
`define SRS_A_STATUS  8'h08
`define SRS_A_FIFO_L  8'h0A
`define SRS_A_FIFO_H  8'h0B
`define SRS_A_IFSEL   8'h0D
`define SRS_A_CFG_A   8'h0F
`define SRS_A_MODE    8'h10
`define SRS_A_RANGE   8'h15
`define SRS_A_FCTRL   8'h16
`define SRS_A_PRES    8'h18
`define SRS_A_CFG_B   8'h1A
`define SRS_A_CFG_C   8'h20
`define SRS_A_CFG_D   8'h21
`define SRS_A_TRIG    8'h24
`define SRS_A_CFG_E   8'h28
`define SRS_A_CAL_OFS 8'h2A
`define SRS_A_CAL_GN  8'h2B
`define SRS_B_RESET   6
`define SRS_B_RELOAD  7
`define SRS_B_I2C_EN  6
`define SRS_B_SPI_EN  7
`define SRS_B_MTRIG   7
`define SRS_B_FIFO_EN 7
`define SRS_B_INT_EN  6
`define SRS_B_SPI_RD  7
`define SRS_M_CWAKE   3'h5
`define SRS_M_TRIG    3'h6
`define SRS_RES_8     3'h0
`define SRS_RES_10    3'h1
`define SRS_RST_BYTE  8'h00
`define SRS_OTP_PRES  8'h5A
`define SRS_OTP_OFS   8'h10
`define SRS_OTP_GN    8'h80
`define SRS_I2C_ID_LO 7'h4C
`define SRS_I2C_ID_HI 7'h6C
`define SRS_SEQ_CYC   5'h10
`define SRS_FIFO_DEP  6'h20
`define SRS_AXES      2'h3
`define SRS_BYTE_END  4'h8
`define SRS_ACK_END   4'h9
`define SRS_SBIT_LAST 3'h7
`endif

// file: verilog/srs_pkg.sv
// state types of the reset/reload sequencer
package srs_pkg;
	typedef enum logic [3:0] {SQ_IDLE = 4'h1, SQ_RESET = 4'h2, SQ_LOAD = 4'h4, SQ_ADDR = 4'h8} srs_seq_e;
	typedef enum logic [4:0] {IP_IDLE = 5'h01, IP_ADDR = 5'h02, IP_REG = 5'h04, IP_WR = 5'h08,
		IP_RD = 5'h10} srs_i2c_e;
	typedef enum logic [2:0] {SP_CMD = 3'h1, SP_WR = 3'h2, SP_RD = 3'h4} srs_spi_e;
endpackage : srs_pkg

// file: verilog/srs_fifo_mem.sv
// 32 x 12 sample store with registered read data
`timescale 1ns/1ns
module srs_fifo_mem
(
	input  wire logic        clk,
	input  wire logic        we,
	input  wire logic [4:0]  waddr,
	input  wire logic [11:0] wdata,
	input  wire logic [4:0]  raddr,
	output logic      [11:0] rdata
);
	logic [11:0] mem [0:31];

	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule : srs_fifo_mem

// file: verilog/srs_ctrl.sv
// soft reset, otp reload and register set behind the shared i2c/spi slave pins
// Functional notes
// - writing bit 6 of register 0x24 runs a full power-on reset
// - reset and reload may be commanded over either i2c or spi
// - after reset and after reload the address-select pin is latched
// - writing bit 7 of register 0x24 copies otp into the register set
// - reload leaves registers without an otp source untouched
// - x, y, z samples sit in per-axis two's complement registers
// - range register selects output resolution and full-scale range
// - 12-bit wide, 32 deep sample fifo with programmable watermark
// - factory offset and gain calibration values are readable
// - samples and status reachable by interrupt or by polling
// - internal clock sampling in continuous wake mode, plus a manual trigger mode
// - both slave ports answer until one enable bit is written
`timescale 1ns/1ns
`include "srs_defs.svh"
module srs_ctrl
	import srs_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        scl_sck,
	input  wire logic        sda_din_in,
	output logic             sda_din_out,
	output logic             sda_din_oe,
	input  wire logic        csn,
	input  wire logic        serial_out_addr_select_pin_in,
	output logic             serial_out_addr_select_pin_out,
	output logic             serial_out_addr_select_pin_oe,
	input  wire logic [11:0] acc_x,
	input  wire logic [11:0] acc_y,
	input  wire logic [11:0] acc_z,
	input  wire logic        sample_tick,
	output logic             int_n,
	output logic [2:0]       range_sel,
	output logic             addr_sel
);
	logic [3:0]  ps1, ps2, ps3;
	logic        scl_r, scl_f, i2c_start, i2c_stop, sda, spi_sel, clr;
	srs_seq_e    seq_ff;
	logic [4:0]  seq_cnt_ff;
	logic [7:0]  if_sel_ff, cfg_a_ff, cfg_b_ff, cfg_c_ff, cfg_d_ff, cfg_e_ff, mode_ff, range_ff, fctrl_ff;
	logic [7:0]  presence_ff, cal_ofs_ff, cal_gn_ff;
	logic [1:0]  trig_ff;
	logic [15:0] x_axis_output_ff, y_axis_output_ff, z_axis_output_ff;
	logic        drdy_ff, ovf_ff, smp_ev, i2c_ok, spi_ok;
	logic [5:0]  wptr_ff, rptr_ff, fcnt;
	logic [1:0]  push_cnt_ff;
	logic        push, pop, full, empty, wm;
	logic [11:0] push_word, fifo_q;
	logic        wr_en, rd_en, i2c_we, i2c_re, spi_we, spi_re;
	logic [7:0]  wr_addr, wr_data, rd_addr, rd_byte;
	srs_i2c_e    ip_ff;
	logic [3:0]  ibit_ff;
	logic [7:0]  isr_ff, itx_ff, iptr_ff;
	logic        irack_ff;
	srs_spi_e    sp_ff;
	logic [2:0]  sbit_ff;
	logic [7:0]  ssr_ff, stx_ff, sptr_ff;

	// pins: s1 feeds s2 only, s3 keeps edge history
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ps1 <= 4'hF;
			ps2 <= 4'hF;
			ps3 <= 4'hF;
		end
		else
		begin
			ps1 <= {scl_sck, sda_din_in, csn, serial_out_addr_select_pin_in};
			ps2 <= ps1;
			ps3 <= ps2;
		end
	end
	assign scl_r     = ps2[3] && !ps3[3];
	assign scl_f     = !ps2[3] && ps3[3];
	assign sda       = ps2[2];
	assign spi_sel   = !ps2[1];
	assign i2c_start = ps2[3] && ps3[3] && !ps2[2] && ps3[2] && !spi_sel;
	assign i2c_stop  = ps2[3] && ps3[3] && ps2[2] && !ps3[2];
	// the reset state doubles as a synchronous clear of every register and engine except addr_sel, the pin stages, the sequencer itself and the fifo memory array
	assign clr       = !rst_n || seq_ff == SQ_RESET;
	assign i2c_ok    = !if_sel_ff[`SRS_B_SPI_EN] || if_sel_ff[`SRS_B_I2C_EN];
	assign spi_ok    = !if_sel_ff[`SRS_B_I2C_EN] || if_sel_ff[`SRS_B_SPI_EN];

	// both slave ports feed one write/read path; they cannot overlap because csn frames spi
	assign wr_en   = i2c_we || spi_we;
	assign wr_addr = spi_we ? sptr_ff : iptr_ff;
	assign wr_data = spi_we ? {ssr_ff[6:0], sda} : isr_ff;
	assign rd_en   = i2c_re || spi_re;
	assign rd_addr = spi_re ? sptr_ff : iptr_ff;

	function automatic logic [15:0] fmt(input logic [11:0] raw, input logic [2:0] res);
		logic [11:0] m;
		m = raw;
		case (res)
		`SRS_RES_8:  m[3:0] = 4'h0;
		`SRS_RES_10: m[1:0] = 2'h0;
		default:     m = raw;
		endcase
		fmt = {{4{m[11]}}, m};
	endfunction : fmt

	function automatic logic [7:0] rd_reg(input logic [7:0] a);
		case (a)
		`SRS_A_XL:      rd_reg = x_axis_output_ff[7:0];
		`SRS_A_XH:      rd_reg = x_axis_output_ff[15:8];
		`SRS_A_YL:      rd_reg = y_axis_output_ff[7:0];
		`SRS_A_YH:      rd_reg = y_axis_output_ff[15:8];
		`SRS_A_ZL:      rd_reg = z_axis_output_ff[7:0];
		`SRS_A_ZH:      rd_reg = z_axis_output_ff[15:8];
		`SRS_A_STATUS:  rd_reg = {2'h0, addr_sel, ovf_ff, wm, full, empty, drdy_ff};
		`SRS_A_FIFO_L:  rd_reg = fifo_q[7:0];
		`SRS_A_FIFO_H:  rd_reg = {4'h0, fifo_q[11:8]};
		`SRS_A_IFSEL:   rd_reg = if_sel_ff;
		`SRS_A_CFG_A:   rd_reg = cfg_a_ff;
		`SRS_A_MODE:    rd_reg = mode_ff;
		`SRS_A_RANGE:   rd_reg = range_ff;
		`SRS_A_FCTRL:   rd_reg = fctrl_ff;
		`SRS_A_PRES:    rd_reg = presence_ff;
		`SRS_A_CFG_B:   rd_reg = cfg_b_ff;
		`SRS_A_CFG_C:   rd_reg = cfg_c_ff;
		`SRS_A_CFG_D:   rd_reg = cfg_d_ff;
		`SRS_A_TRIG:    rd_reg = {trig_ff, 6'h00};
		`SRS_A_CFG_E:   rd_reg = cfg_e_ff;
		`SRS_A_CAL_OFS: rd_reg = cal_ofs_ff;
		`SRS_A_CAL_GN:  rd_reg = cal_gn_ff;
		default:        rd_reg = `SRS_RST_BYTE;
		endcase
	endfunction : rd_reg

	always_comb
		rd_byte = rd_reg(rd_addr);

	// sequencer: power-up takes the same path as a commanded reset
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			seq_ff     <= SQ_RESET;
			seq_cnt_ff <= 5'h00;
		end
		else
			case (seq_ff)
			SQ_IDLE:
			begin
				seq_cnt_ff <= 5'h00;
				if (trig_ff[0])
					seq_ff <= SQ_RESET;
				else if (trig_ff[1])
					seq_ff <= SQ_LOAD;
			end
			SQ_RESET:
			begin
				seq_cnt_ff <= seq_cnt_ff + 5'h01;
				if (seq_cnt_ff == `SRS_SEQ_CYC)
					seq_ff <= SQ_LOAD;
			end
			SQ_LOAD:
				seq_ff <= SQ_ADDR;
			SQ_ADDR:
				seq_ff <= SQ_IDLE;
			default:
				seq_ff <= SQ_IDLE;
			endcase
	end

	// the pin is sampled after the fabric is quiet, spi output is released by then
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			addr_sel <= 1'b0;
		else if (seq_ff == SQ_ADDR)
			addr_sel <= ps2[0];
	end

	// register set; writes come last so a set beats a same-cycle self-clear
	always_ff @(posedge core_clk)
	begin
		if (clr)
		begin
			if_sel_ff   <= `SRS_RST_BYTE;
			cfg_a_ff    <= `SRS_RST_BYTE;
			cfg_b_ff    <= `SRS_RST_BYTE;
			cfg_c_ff    <= `SRS_RST_BYTE;
			cfg_d_ff    <= `SRS_RST_BYTE;
			cfg_e_ff    <= `SRS_RST_BYTE;
			mode_ff     <= `SRS_RST_BYTE;
			range_ff    <= `SRS_RST_BYTE;
			fctrl_ff    <= `SRS_RST_BYTE;
			presence_ff <= `SRS_RST_BYTE;
			cal_ofs_ff  <= `SRS_RST_BYTE;
			cal_gn_ff   <= `SRS_RST_BYTE;
			trig_ff     <= 2'h0;
		end
		else
		begin
			if (seq_ff == SQ_LOAD)
			begin
				presence_ff <= `SRS_OTP_PRES;
				cal_ofs_ff  <= `SRS_OTP_OFS;
				cal_gn_ff   <= `SRS_OTP_GN;
			end
			if (seq_ff == SQ_IDLE)
				trig_ff <= 2'h0;
			if (mode_ff[`SRS_B_MTRIG])
				mode_ff[`SRS_B_MTRIG] <= 1'b0;
			if (wr_en)
				case (wr_addr)
				`SRS_A_IFSEL: if_sel_ff <= wr_data;
				`SRS_A_CFG_A: cfg_a_ff <= wr_data;
				`SRS_A_CFG_B: cfg_b_ff <= wr_data;
				`SRS_A_CFG_C: cfg_c_ff <= wr_data;
				`SRS_A_CFG_D: cfg_d_ff <= wr_data;
				`SRS_A_CFG_E: cfg_e_ff <= wr_data;
				`SRS_A_MODE:  mode_ff <= wr_data;
				`SRS_A_RANGE: range_ff <= wr_data;
				`SRS_A_FCTRL: fctrl_ff <= wr_data;
				`SRS_A_TRIG:  trig_ff <= {wr_data[`SRS_B_RELOAD], wr_data[`SRS_B_RESET]};
				default:      trig_ff <= trig_ff;
				endcase
		end
	end

	// samples: internal tick in continuous wake, or one manual shot in trigger mode
	assign smp_ev = (sample_tick && mode_ff[2:0] == `SRS_M_CWAKE)
		|| (mode_ff[`SRS_B_MTRIG] && mode_ff[2:0] == `SRS_M_TRIG);
	always_ff @(posedge core_clk)
	begin
		if (clr)
		begin
			x_axis_output_ff <= 16'h0000;
			y_axis_output_ff <= 16'h0000;
			z_axis_output_ff <= 16'h0000;
			drdy_ff          <= 1'b0;
			ovf_ff           <= 1'b0;
		end
		else
		begin
			if (smp_ev)
			begin
				x_axis_output_ff <= fmt(acc_x, range_ff[2:0]);
				y_axis_output_ff <= fmt(acc_y, range_ff[2:0]);
				z_axis_output_ff <= fmt(acc_z, range_ff[2:0]);
			end
			drdy_ff <= smp_ev || (drdy_ff && !(rd_en && rd_addr == `SRS_A_STATUS));
			ovf_ff  <= (push_cnt_ff != 2'h0 && full) || (ovf_ff && !(rd_en && rd_addr == `SRS_A_STATUS));
		end
	end

	// fifo: three words per sample, dropped with overflow flagged when full
	assign fcnt  = wptr_ff - rptr_ff;
	assign full  = fcnt == `SRS_FIFO_DEP;
	assign empty = fcnt == 6'h00;
	assign wm    = !empty && fcnt >= {1'b0, fctrl_ff[4:0]};
	assign push  = push_cnt_ff != 2'h0 && !full;
	assign pop   = rd_en && rd_addr == `SRS_A_FIFO_H && !empty;
	always_comb
	begin
		case (push_cnt_ff)
		`SRS_AXES: push_word = x_axis_output_ff[11:0];
		2'h2:      push_word = y_axis_output_ff[11:0];
		default:   push_word = z_axis_output_ff[11:0];
		endcase
	end
	always_ff @(posedge core_clk)
	begin
		if (clr)
		begin
			wptr_ff     <= 6'h00;
			rptr_ff     <= 6'h00;
			push_cnt_ff <= 2'h0;
		end
		else
		begin
			if (smp_ev && fctrl_ff[`SRS_B_FIFO_EN])
				push_cnt_ff <= `SRS_AXES;
			else if (push_cnt_ff != 2'h0)
				push_cnt_ff <= push_cnt_ff - 2'h1;
			if (push)
				wptr_ff <= wptr_ff + 6'h01;
			if (pop)
				rptr_ff <= rptr_ff + 6'h01;
		end
	end
	srs_fifo_mem u_mem
	(
		.clk   (core_clk),
		.we    (push),
		.waddr (wptr_ff[4:0]),
		.wdata (push_word),
		.raddr (rptr_ff[4:0]),
		.rdata (fifo_q)
	);

	always_ff @(posedge core_clk)
	begin
		if (clr)
		begin
			int_n     <= 1'b1;
			range_sel <= 3'h0;
		end
		else
		begin
			int_n     <= !(fctrl_ff[`SRS_B_INT_EN] && (drdy_ff || wm));
			range_sel <= range_ff[6:4];
		end
	end

	// i2c slave; ack and data are driven on scl falls, sampled on rises
	assign i2c_we = scl_f && ibit_ff == `SRS_BYTE_END && ip_ff == IP_WR;
	assign i2c_re = scl_f && ibit_ff == `SRS_ACK_END && ip_ff == IP_RD && irack_ff;
	always_ff @(posedge core_clk)
	begin
		if (clr || spi_sel || i2c_stop)
		begin
			ip_ff       <= IP_IDLE;
			ibit_ff     <= 4'h0;
			sda_din_oe  <= 1'b0;
			sda_din_out <= 1'b0;
			irack_ff    <= 1'b0;
			if (clr)
			begin
				isr_ff  <= 8'h00;
				itx_ff  <= 8'h00;
				iptr_ff <= 8'h00;
			end
		end
		else if (i2c_start)
		begin
			ip_ff      <= IP_ADDR;
			ibit_ff    <= 4'h0;
			sda_din_oe <= 1'b0;
		end
		else if (scl_r && ip_ff != IP_IDLE)
		begin
			if (ibit_ff == `SRS_BYTE_END)
				irack_ff <= !sda;
			else
				isr_ff <= {isr_ff[6:0], sda};
			ibit_ff <= ibit_ff + 4'h1;
		end
		else if (scl_f && ip_ff != IP_IDLE)
		begin
			if (ibit_ff == `SRS_BYTE_END)
				case (ip_ff)
				IP_ADDR:
					if (i2c_ok && isr_ff[7:1] == (addr_sel ? `SRS_I2C_ID_HI : `SRS_I2C_ID_LO))
					begin
						sda_din_oe <= 1'b1;
						ip_ff      <= isr_ff[0] ? IP_RD : IP_REG;
					end
					else
						ip_ff <= IP_IDLE;
				IP_REG:
				begin
					iptr_ff    <= isr_ff;
					sda_din_oe <= 1'b1;
					ip_ff      <= IP_WR;
				end
				IP_WR:
				begin
					iptr_ff    <= iptr_ff + 8'h01;
					sda_din_oe <= 1'b1;
				end
				default:
					sda_din_oe <= 1'b0;
				endcase
			else if (ibit_ff == `SRS_ACK_END)
			begin
				ibit_ff    <= 4'h0;
				sda_din_oe <= i2c_re && !rd_byte[7];
				if (i2c_re)
				begin
					itx_ff  <= rd_byte;
					iptr_ff <= iptr_ff + 8'h01;
				end
				else if (ip_ff == IP_RD)
					ip_ff <= IP_IDLE;
			end
			else if (ip_ff == IP_RD)
			begin
				sda_din_oe <= !itx_ff[6];
				itx_ff     <= {itx_ff[6:0], 1'b0};
			end
		end
	end

	// spi slave, mode 0: command byte bit 7 selects read, bits 6:0 the start address
	assign spi_we = scl_r && sbit_ff == `SRS_SBIT_LAST && sp_ff == SP_WR;
	assign spi_re = scl_f && sbit_ff == 3'h0 && sp_ff == SP_RD;
	always_ff @(posedge core_clk)
	begin
		if (clr || !spi_sel || !spi_ok)
		begin
			sp_ff                          <= SP_CMD;
			sbit_ff                        <= 3'h0;
			serial_out_addr_select_pin_oe  <= 1'b0;
			serial_out_addr_select_pin_out <= 1'b0;
			if (clr)
			begin
				ssr_ff  <= 8'h00;
				stx_ff  <= 8'h00;
				sptr_ff <= 8'h00;
			end
		end
		else
		begin
			serial_out_addr_select_pin_oe <= sp_ff == SP_RD;
			if (scl_r)
			begin
				ssr_ff  <= {ssr_ff[6:0], sda};
				sbit_ff <= sbit_ff + 3'h1;
				if (sbit_ff == `SRS_SBIT_LAST && sp_ff == SP_CMD)
				begin
					sptr_ff <= {1'b0, ssr_ff[5:0], sda};
					sp_ff   <= ssr_ff[6] ? SP_RD : SP_WR;
				end
				else if (spi_we)
					sptr_ff <= sptr_ff + 8'h01;
			end
			else if (spi_re)
			begin
				stx_ff                         <= rd_byte;
				serial_out_addr_select_pin_out <= rd_byte[7];
				sptr_ff                        <= sptr_ff + 8'h01;
			end
			else if (scl_f && sp_ff == SP_RD)
			begin
				serial_out_addr_select_pin_out <= stx_ff[6];
				stx_ff                         <= {stx_ff[6:0], 1'b0};
			end
		end
	end

	default clocking dcb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	a_reset_cmd_start: assert property (wr_en && wr_addr == `SRS_A_TRIG && wr_data[`SRS_B_RESET]
		&& seq_ff == SQ_IDLE |-> ##2 seq_ff == SQ_RESET) else $error("reset command not started");
	a_reset_clears_regs: assert property (seq_ff == SQ_RESET |=> cfg_e_ff == `SRS_RST_BYTE
		&& trig_ff == 2'h0 && ip_ff == IP_IDLE) else $error("reset left state behind");
	a_reload_cmd_start: assert property (wr_en && wr_addr == `SRS_A_TRIG && wr_data[`SRS_B_RELOAD]
		&& !wr_data[`SRS_B_RESET] && seq_ff == SQ_IDLE |-> ##2 seq_ff == SQ_LOAD) else $error("reload not started");
	a_reload_otp_copy: assert property (seq_ff == SQ_LOAD |=> presence_ff == `SRS_OTP_PRES
		&& cal_gn_ff == `SRS_OTP_GN && cal_ofs_ff == `SRS_OTP_OFS) else $error("otp image not loaded");
	a_reload_keeps_rest: assert property (seq_ff == SQ_LOAD && !wr_en |=> cfg_a_ff == $past(cfg_a_ff)
		&& if_sel_ff == $past(if_sel_ff)) else $error("reload disturbed a plain register");
	a_addr_pin_latch: assert property (seq_ff == SQ_LOAD |=> ##1 addr_sel == $past(ps2[0]))
		else $error("address pin not latched");
	a_trig_self_clear: assert property (seq_ff == SQ_IDLE && trig_ff != 2'h0 && !wr_en |=> trig_ff == 2'h0)
		else $error("trigger bit stuck");
	a_iface_gate: assert property (if_sel_ff[`SRS_B_SPI_EN] && !if_sel_ff[`SRS_B_I2C_EN] |-> !i2c_we && !i2c_re)
		else $error("i2c answered while disabled");
	a_fifo_bound: assert property (fcnt <= `SRS_FIFO_DEP) else $error("fifo count above depth");
	a_res_mask: assert property (smp_ev && range_ff[2:0] == `SRS_RES_8 |=> x_axis_output_ff[3:0] == 4'h0
		&& x_axis_output_ff[15:12] == {4{x_axis_output_ff[11]}}) else $error("sample format wrong");
	a_int_on_ready: assert property (smp_ev && fctrl_ff[`SRS_B_INT_EN] |=> ##1 !int_n)
		else $error("interrupt not raised");
	c_reset_done: cover property (seq_ff == SQ_RESET ##[1:40] seq_ff == SQ_IDLE);
	c_i2c_write: cover property (i2c_we && wr_addr == `SRS_A_TRIG);
	c_spi_read: cover property (spi_re ##[1:100] spi_re);
	c_fifo_full: cover property (full);
endmodule : srs_ctrl

// file: verif/srs_host.sv
// host master model that drives the shared i2c/spi pins
`timescale 1ns/1ns
module srs_host
(
	input  wire logic core_clk,
	input  wire logic sda_line,
	input  wire logic miso_line,
	output logic      scl_sck,
	output logic      sda_drv,
	output logic      csn
);
	// 4 core cycles a phase gives the 400 ns link clock; the clock stands still between frames
	localparam int PH = 4;
	initial
	begin
		scl_sck = 1'b1;
		sda_drv = 1'b1;
		csn     = 1'b1;
	end
	task automatic ph(input int n);
		repeat (n) @(posedge core_clk);
	endtask : ph
	// sampled late in the high phase, after the device's synchroniser latency
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		ph(PH);
		scl_sck <= 1'b1;
		ph(PH);
		r = csn ? sda_line : miso_line;
		scl_sck <= 1'b0;
	endtask : bit_io
	task automatic byte_io(input logic [7:0] d, input logic m9, output logic [7:0] r, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], b);
			r[i] = b;
		end
		if (csn)
		begin
			bit_io(m9, b);
			ack = !b;
		end
	endtask : byte_io
	task automatic i2c_start();
		sda_drv <= 1'b1;
		ph(PH);
		scl_sck <= 1'b1;
		ph(PH);
		sda_drv <= 1'b0;
		ph(PH);
		scl_sck <= 1'b0;
	endtask : i2c_start
	task automatic i2c_stop();
		sda_drv <= 1'b0;
		ph(PH);
		scl_sck <= 1'b1;
		ph(PH);
		sda_drv <= 1'b1;
		ph(PH);
	endtask : i2c_stop
	task automatic i2c_wr(input logic [6:0] id, input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       k0, k1, k2;
		i2c_start();
		byte_io({id, 1'b0}, 1'b1, r, k0);
		byte_io(a, 1'b1, r, k1);
		byte_io(d, 1'b1, r, k2);
		i2c_stop();
		ok = k0 & k1 & k2;
	endtask : i2c_wr
	// last byte is refused by the master so the device lets go of the line
	task automatic i2c_rd(input logic [6:0] id, input logic [7:0] a, output logic [7:0] r, output logic ok);
		logic [7:0] x;
		logic       k0, k1, k2, k3;
		i2c_start();
		byte_io({id, 1'b0}, 1'b1, x, k0);
		byte_io(a, 1'b1, x, k1);
		i2c_start();
		byte_io({id, 1'b1}, 1'b1, x, k2);
		byte_io(8'hFF, 1'b1, r, k3);
		i2c_stop();
		ok = k0 & k1 & k2;
	endtask : i2c_rd
	// mode 0: clock low at chip select fall, data taken at each rise
	task automatic spi_xfer(input logic [7:0] c, input logic [7:0] d, output logic [7:0] r);
		logic [7:0] x;
		logic       k;
		scl_sck <= 1'b0;
		ph(PH);
		csn <= 1'b0;
		ph(PH);
		byte_io(c, 1'b0, x, k);
		byte_io(d, 1'b0, r, k);
		ph(PH);
		csn <= 1'b1;
		ph(PH);
	endtask : spi_xfer
endmodule : srs_host

// file: verif/srs_ctrl_test.sv
// self-checking bench of the reset/reload sequencer driven by the host model
`timescale 1ns/1ns
module srs_ctrl_test;
	logic        core_clk, rst_n, strap, sample_tick;
	logic [11:0] acc_x, acc_y, acc_z;
	logic        scl_sck, sda_drv, csn, sda_out, sda_oe, miso_out, miso_oe;
	logic        int_n, addr_sel, sda_line, miso_line, ok;
	logic [2:0]  range_sel;
	logic [6:0]  id;
	logic [7:0]  r;
	int          miscompares, num_checks;
	logic [7:0]  init_a [5] = '{8'h0F, 8'h20, 8'h21, 8'h28, 8'h1A};
	logic [7:0]  init_d [5] = '{8'h42, 8'h01, 8'h80, 8'h00, 8'h00};
	// open drain data line with pull-up; the strap holds the pin whenever miso is released
	assign sda_line  = sda_oe ? sda_out : sda_drv;
	assign miso_line = miso_oe ? miso_out : strap;
	srs_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .scl_sck(scl_sck), .sda_din_in(sda_line),
		.sda_din_out(sda_out), .sda_din_oe(sda_oe), .csn(csn), .serial_out_addr_select_pin_in(miso_line),
		.serial_out_addr_select_pin_out(miso_out), .serial_out_addr_select_pin_oe(miso_oe),
		.acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z), .sample_tick(sample_tick), .int_n(int_n),
		.range_sel(range_sel), .addr_sel(addr_sel));
	srs_host host_u (.core_clk(core_clk), .sda_line(sda_line), .miso_line(miso_line),
		.scl_sck(scl_sck), .sda_drv(sda_drv), .csn(csn));
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic iw(input logic [7:0] a, input logic [7:0] d);
		host_u.i2c_wr(id, a, d, ok);
		chk({7'h00, ok}, 8'h01);
	endtask : iw
	task automatic ir(input logic [7:0] a, input logic [7:0] e);
		host_u.i2c_rd(id, a, r, ok);
		chk({7'h00, ok}, 8'h01);
		chk(r, e);
	endtask : ir
	task automatic sw(input logic [7:0] a, input logic [7:0] d);
		host_u.spi_xfer({1'b0, a[6:0]}, d, r);
	endtask : sw
	task automatic sr(input logic [7:0] a, input logic [7:0] e);
		host_u.spi_xfer({1'b1, a[6:0]}, 8'h00, r);
		chk(r, e);
	endtask : sr
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial
	begin
		cyc(90000);
		miscompares++;
		test_done();
	end
	initial
	begin
		{rst_n, strap, sample_tick, acc_x, acc_y, acc_z} = '0;
		id = 7'h4C;
		miscompares = 0;
		num_checks = 0;
		cyc(3);
		rst_n <= 1'b1;
		cyc(30);
		chk({7'h00, addr_sel}, 8'h00);
		ir(8'h18, 8'h5A);
		sr(8'h18, 8'h5A);
		$display("test power_up done");
		iw(8'h10, 8'h01);
		iw(8'h0F, 8'h42);
		ir(8'h0F, 8'h42);
		strap <= 1'b1;
		host_u.i2c_wr(id, 8'h24, 8'h40, ok);
		cyc(20000);
		chk({7'h00, addr_sel}, 8'h01);
		id = 7'h6C;
		ir(8'h0F, 8'h00);
		ir(8'h24, 8'h00);
		iw(8'h0D, 8'h40);
		for (int i = 0; i < 5; i++)
			iw(init_a[i], init_d[i]);
		for (int i = 0; i < 5; i++)
			ir(init_a[i], init_d[i]);
		// spi is off now, so the pin only shows the strap level
		sr(8'h18, 8'hFF);
		$display("test i2c_reset done");
		iw(8'h0D, 8'h80);
		sr(8'h0D, 8'h80);
		sw(8'h10, 8'h01);
		strap <= 1'b0;
		sw(8'h24, 8'h80);
		cyc(20000);
		chk({7'h00, addr_sel}, 8'h00);
		sr(8'h2A, 8'h10);
		sr(8'h2B, 8'h80);
		sr(8'h0F, 8'h42);
		sr(8'h0D, 8'h80);
		sr(8'h24, 8'h00);
		id = 7'h4C;
		host_u.i2c_rd(id, 8'h18, r, ok);
		chk({7'h00, ok}, 8'h00);
		$display("test spi_reload done");
		sw(8'h24, 8'h40);
		cyc(20000);
		ir(8'h18, 8'h5A);
		sr(8'h18, 8'h5A);
		for (int i = 0; i < 4 && r !== 8'h80; i++)
		begin
			sw(8'h0D, 8'h80);
			host_u.spi_xfer(8'h8D, 8'h00, r);
		end
		chk(r, 8'h80);
		// the 10 ms mode settling wait is left out: this block has no mode clock
		for (int i = 0; i < 5; i++)
		begin
			sw(init_a[i], init_d[i]);
			if (i == 0)
				sw(8'h10, 8'h01);
		end
		sr(8'h21, 8'h80);
		$display("test spi_reset done");
		sw(8'h15, 8'h32);
		chk({5'h00, range_sel}, 8'h03);
		sw(8'h10, 8'h05);
		acc_x <= 12'hF85;
		acc_y <= 12'h07F;
		acc_z <= 12'h800;
		sample_tick <= 1'b1;
		cyc(1);
		sample_tick <= 1'b0;
		cyc(10);
		sr(8'h08, 8'h03);
		sr(8'h02, 8'h85);
		sr(8'h03, 8'hFF);
		sr(8'h04, 8'h7F);
		sr(8'h05, 8'h00);
		sr(8'h06, 8'h00);
		sr(8'h07, 8'hF8);
		$display("test samples done");
		// 8-bit resolution, fifo on with watermark 1, interrupt on; one manual trigger shot
		sw(8'h15, 8'h30);
		sw(8'h16, 8'hC1);
		chk({7'h00, int_n}, 8'h01);
		sw(8'h10, 8'h86);
		chk({7'h00, int_n}, 8'h00);
		sr(8'h08, 8'h09);
		sr(8'h02, 8'h80);
		sr(8'h0A, 8'h80);
		$display("test fifo done");
		test_done();
	end
endmodule : srs_ctrl_test
